// file: shared/faepc_pkg.sv
// constants and types shared by the flash array control block
// Functional notes
// - erased bits read 0, programmed bits read 1
// - rows of eight 8-byte pages; smallest erase unit is one 64-byte row
// - one program operation writes one eight-byte page
// - array answers in two windows; control register at one fixed address
// - high-voltage enable needs program or erase plus completed sequence steps
// - high-voltage enable high runs pump and drives high voltage
// - setting margin-read while high voltage is on is dropped to 0
// - erase and program select are never both set
// - pump divider: 00 by one, 01/10 by two, 11 by four
// - block-select picks full, half, eight rows or one row extent
// - target write latches significant address bits; code 00 selects all
// - protect read latches; overlap with protected block clears program/erase
// - margin-mode array reads stretched nine extra bus cycles
package faepc_pkg;
  localparam logic [15:0] CTRL_ADDR    = 16'hfe11;
  localparam logic [15:0] PROTECT_ADDR = 16'hff81;
  localparam logic [15:0] WIN0_LO      = 16'h0450;
  localparam logic [15:0] WIN0_HI      = 16'h05ff;
  localparam logic [15:0] WIN1_LO      = 16'h0e00;
  localparam logic [15:0] WIN1_HI      = 16'h7fff;
  // protect bit base addresses, each protects up to WIN1_HI
  localparam logic [15:0] PROT3_LO     = 16'h4000;
  localparam logic [15:0] PROT2_LO     = 16'h2000;
  localparam logic [15:0] PROT1_LO     = 16'h1000;
  localparam logic [15:0] PROT0_LO     = 16'h0450;
  // control register bit positions
  localparam int BIT_DIV_HIGH  = 7;
  localparam int BIT_DIV_LOW   = 6;
  localparam int BIT_SIZE_HIGH = 5;
  localparam int BIT_SIZE_LOW  = 4;
  localparam int BIT_HV        = 3;
  localparam int BIT_MARGIN    = 2;
  localparam int BIT_ERASE     = 1;
  localparam int BIT_PROG      = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int PAGE_BYTES    = 8;
  localparam int ROW_BYTES     = 64;
  localparam logic [3:0] MARGIN_STRETCH = 4'h8;
  localparam logic [1:0] SIZE_FULL  = 2'h0;
  localparam logic [1:0] SIZE_HALF  = 2'h1;
  localparam logic [1:0] SIZE_EIGHT = 2'h2;
  localparam logic [1:0] SIZE_ROW   = 2'h3;
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_ARMED,
    SEQ_CHECKED,
    SEQ_READY
  } faepc_seq_type;
endpackage : faepc_pkg

// file: hw/faepc_pump_div.sv
// pump clock enable divider
`timescale 1ns/1ps
module faepc_pump_div (
  input  wire logic       core_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       run_i,
  input  wire logic [1:0] div_i,
  output logic            pump_en_o
);
  typedef struct packed {
    logic [1:0] cnt;
    logic       en;
  } faepc_div_type;
  faepc_div_type div_reg, div_next;
  logic [1:0] last;
  always_comb begin
    div_next = div_reg;
    case (div_i)
      2'h0:    last = 2'h0;
      2'h3:    last = 2'h3;
      default: last = 2'h1;
    endcase
    if (!run_i) begin
      div_next.cnt = 2'h0;
      div_next.en  = 1'b0;
    end else if (div_reg.cnt >= last) begin
      div_next.cnt = 2'h0;
      div_next.en  = 1'b1;
    end else begin
      div_next.cnt = div_reg.cnt + 2'h1;
      div_next.en  = 1'b0;
    end
  end
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end
  assign pump_en_o = div_reg.en;
  property p_div_four;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (run_i && div_i == 2'h3 && div_reg.en) ##1 (run_i && div_i == 2'h3) [*3]
        |-> !div_reg.en;
  endproperty
  a_div_four: assert property (p_div_four) else $error("divide by four too fast");
endmodule : faepc_pump_div

// file: hw/faepc_stretch.sv
// margin-read access stretch counter
`timescale 1ns/1ps
module faepc_stretch (
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic start_i,
  output logic      busy_o,
  output logic      done_o
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       busy;
    logic       done;
  } faepc_str_type;
  faepc_str_type st_reg, st_next;
  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    if (st_reg.busy) begin
      if (st_reg.cnt == faepc_pkg::MARGIN_STRETCH) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + 4'h1;
      end
    end else if (start_i) begin
      st_next.busy = 1'b1;
      st_next.cnt  = 4'h1;
    end
  end
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign busy_o = st_reg.busy;
  assign done_o = st_reg.done;
  property p_stretch_len;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (start_i && !st_reg.busy) |=> st_reg.busy [*8] ##1 st_reg.done;
  endproperty
  a_stretch_len: assert property (p_stretch_len) else $error("stretch not eight cycles");
endmodule : faepc_stretch

// file: hw/faepc_ctrl.sv
// flash array control register, erase addressing, protection and access timing
`timescale 1ns/1ps
module faepc_ctrl (
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [7:0]  protect_data_i,
  input  wire logic [7:0]  array_data_i,
  output logic [7:0]       rdata_o,
  output logic             rvalid_o,
  output logic             high_voltage_o,
  output logic             pump_clk_en_o,
  output logic             margin_mode_o,
  output logic             erase_mode_o,
  output logic             program_mode_o,
  output logic [1:0]       erase_size_o,
  output logic [15:0]      erase_addr_o,
  output logic             erase_go_o,
  output logic             page_wr_o,
  output logic [15:0]      page_addr_o,
  output logic [7:0]       page_data_o
);
  typedef struct packed {
    logic [7:0]              ctrl;
    faepc_pkg::faepc_seq_type seq;
    logic [15:0]             target;
    logic [3:0]              prot;
    logic [2:0]              page_cnt;
    logic [7:0]              rdata;
    logic                    rvalid;
    logic                    erase_go;
    logic                    page_wr;
    logic [15:0]             page_addr;
    logic [7:0]              page_data;
    logic                    pend;
    logic [15:0]             pend_addr;
  } faepc_ctl_type;
  faepc_ctl_type s_reg, s_next;

  logic in_array;
  logic is_ctrl;
  logic is_prot;
  logic str_busy;
  logic str_done;
  logic str_start;
  logic pump_en;
  logic overlap;
  logic [15:0] lo_bound;
  logic [7:0]  w;

  assign in_array = (addr_i >= faepc_pkg::WIN0_LO && addr_i <= faepc_pkg::WIN0_HI) ||
                    (addr_i >= faepc_pkg::WIN1_LO && addr_i <= faepc_pkg::WIN1_HI);
  assign is_ctrl  = (addr_i == faepc_pkg::CTRL_ADDR);
  assign is_prot  = (addr_i == faepc_pkg::PROTECT_ADDR);
  assign str_start = rd_i && in_array && s_reg.ctrl[faepc_pkg::BIT_MARGIN];

  faepc_stretch u_stretch (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .start_i    (str_start),
    .busy_o     (str_busy),
    .done_o     (str_done)
  );

  faepc_pump_div u_div (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .run_i      (s_reg.ctrl[faepc_pkg::BIT_HV]),
    .div_i      (s_reg.ctrl[7:6]),
    .pump_en_o  (pump_en)
  );

  // lowest protected address from the latched protect byte
  always_comb begin
    if (s_reg.prot[0]) begin
      lo_bound = faepc_pkg::PROT0_LO;
    end else if (s_reg.prot[1]) begin
      lo_bound = faepc_pkg::PROT1_LO;
    end else if (s_reg.prot[2]) begin
      lo_bound = faepc_pkg::PROT2_LO;
    end else if (s_reg.prot[3]) begin
      lo_bound = faepc_pkg::PROT3_LO;
    end else begin
      lo_bound = faepc_pkg::WIN1_HI;
    end
  end

  // conservative: any erase extent or page at or above the bound is refused
  always_comb begin
    overlap = 1'b0;
    if (s_reg.prot != 4'h0) begin
      if (s_reg.ctrl[faepc_pkg::BIT_ERASE] &&
          s_reg.ctrl[5:4] != faepc_pkg::SIZE_ROW) begin
        overlap = 1'b1;
      end else begin
        overlap = (s_reg.target | 16'h003f) >= lo_bound;
      end
    end
  end

  always_comb begin
    s_next          = s_reg;
    s_next.erase_go = 1'b0;
    s_next.page_wr  = 1'b0;
    s_next.rvalid   = 1'b0;
    w               = wdata_i;
    if (wr_i && is_ctrl) begin
      if (w[faepc_pkg::BIT_ERASE] && w[faepc_pkg::BIT_PROG]) begin
        w[faepc_pkg::BIT_PROG] = 1'b0;
      end
      if (w[faepc_pkg::BIT_MARGIN] &&
          (s_reg.ctrl[faepc_pkg::BIT_HV] || w[faepc_pkg::BIT_HV])) begin
        w[faepc_pkg::BIT_MARGIN] = 1'b0;
      end
      if (w[faepc_pkg::BIT_HV] && !s_reg.ctrl[faepc_pkg::BIT_HV] &&
          !(s_reg.seq == faepc_pkg::SEQ_READY &&
            (w[faepc_pkg::BIT_ERASE] || w[faepc_pkg::BIT_PROG]))) begin
        w[faepc_pkg::BIT_HV] = 1'b0;
      end
      if (!w[faepc_pkg::BIT_ERASE] && !w[faepc_pkg::BIT_PROG]) begin
        s_next.seq = faepc_pkg::SEQ_IDLE;
      end else if (s_reg.seq == faepc_pkg::SEQ_IDLE ||
                   w[1:0] != s_reg.ctrl[1:0]) begin
        s_next.seq      = faepc_pkg::SEQ_ARMED;
        s_next.page_cnt = 3'h0;
      end
      // hv falling in erase mode marks the erase complete
      if (s_reg.ctrl[faepc_pkg::BIT_HV] && !w[faepc_pkg::BIT_HV] &&
          s_reg.ctrl[faepc_pkg::BIT_ERASE]) begin
        s_next.erase_go = 1'b1;
      end
      s_next.ctrl = w;
    end
    if (rd_i && is_prot && s_reg.seq == faepc_pkg::SEQ_ARMED) begin
      s_next.prot = protect_data_i[3:0];
      s_next.seq  = faepc_pkg::SEQ_CHECKED;
    end
    if (wr_i && in_array && s_reg.seq != faepc_pkg::SEQ_IDLE) begin
      if (s_reg.ctrl[faepc_pkg::BIT_ERASE]) begin
        case (s_reg.ctrl[5:4])
          faepc_pkg::SIZE_FULL:  s_next.target = faepc_pkg::WIN0_LO;
          faepc_pkg::SIZE_HALF:  s_next.target = {1'b0, addr_i[14], 14'h0000};
          faepc_pkg::SIZE_EIGHT: s_next.target = {1'b0, addr_i[14:9], 9'h000};
          default:               s_next.target = {1'b0, addr_i[14:6], 6'h00};
        endcase
        if (s_reg.seq == faepc_pkg::SEQ_CHECKED) begin
          s_next.seq = faepc_pkg::SEQ_READY;
        end
      end else if (s_reg.ctrl[faepc_pkg::BIT_PROG]) begin
        // page bytes are latched and forwarded one at a time
        s_next.target    = {addr_i[15:3], 3'h0};
        s_next.page_wr   = 1'b1;
        s_next.page_addr = addr_i;
        s_next.page_data = wdata_i;
        s_next.page_cnt  = s_reg.page_cnt + 3'h1;
        if (s_reg.page_cnt == 3'(faepc_pkg::PAGE_BYTES - 1) &&
            s_reg.seq == faepc_pkg::SEQ_CHECKED) begin
          s_next.seq = faepc_pkg::SEQ_READY;
        end
      end
    end
    // protected target: drop program and erase, hv cannot follow
    if (s_reg.seq == faepc_pkg::SEQ_READY && overlap) begin
      s_next.ctrl[faepc_pkg::BIT_ERASE] = 1'b0;
      s_next.ctrl[faepc_pkg::BIT_PROG]  = 1'b0;
      s_next.ctrl[faepc_pkg::BIT_HV]    = 1'b0;
      s_next.seq                        = faepc_pkg::SEQ_IDLE;
    end
    if (rd_i && is_ctrl) begin
      s_next.rdata  = s_reg.ctrl;
      s_next.rvalid = 1'b1;
    end else if (rd_i && in_array && !s_reg.ctrl[faepc_pkg::BIT_MARGIN]) begin
      s_next.rdata  = array_data_i;
      s_next.rvalid = 1'b1;
    end else if (rd_i && in_array) begin
      s_next.pend      = 1'b1;
      s_next.pend_addr = addr_i;
    end else if (rd_i) begin
      s_next.rdata  = 8'h00;
      s_next.rvalid = 1'b1;
    end
    if (str_done && s_reg.pend) begin
      s_next.rdata  = array_data_i;
      s_next.rvalid = 1'b1;
      s_next.pend   = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_reg      <= '0;
      s_reg.ctrl <= faepc_pkg::CTRL_RESET;
      s_reg.seq  <= faepc_pkg::SEQ_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata_o        = s_reg.rdata;
  assign rvalid_o       = s_reg.rvalid;
  assign high_voltage_o = s_reg.ctrl[faepc_pkg::BIT_HV];
  assign pump_clk_en_o  = pump_en;
  assign margin_mode_o  = s_reg.ctrl[faepc_pkg::BIT_MARGIN];
  assign erase_mode_o   = s_reg.ctrl[faepc_pkg::BIT_ERASE];
  assign program_mode_o = s_reg.ctrl[faepc_pkg::BIT_PROG];
  assign erase_size_o   = s_reg.ctrl[5:4];
  assign erase_addr_o   = s_reg.target;
  assign erase_go_o     = s_reg.erase_go;
  assign page_wr_o      = s_reg.page_wr;
  assign page_addr_o    = s_reg.page_addr;
  assign page_data_o    = s_reg.page_data;

  property p_never_both;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      !(s_reg.ctrl[faepc_pkg::BIT_ERASE] && s_reg.ctrl[faepc_pkg::BIT_PROG]);
  endproperty
  a_never_both: assert property (p_never_both) else $error("erase and program both set");

  property p_hv_needs_mode;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      $rose(high_voltage_o) |-> (erase_mode_o || program_mode_o) && $past(s_reg.seq) ==
        faepc_pkg::SEQ_READY;
  endproperty
  a_hv_needs_mode: assert property (p_hv_needs_mode) else $error("hv set out of sequence");

  property p_margin_hv;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      high_voltage_o |-> !margin_mode_o;
  endproperty
  a_margin_hv: assert property (p_margin_hv) else $error("margin set with hv on");

  property p_pump_off;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      !high_voltage_o ##1 !high_voltage_o |-> !pump_clk_en_o;
  endproperty
  a_pump_off: assert property (p_pump_off) else $error("pump runs with hv off");

  property p_ctrl_read;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (rd_i && is_ctrl) |=> rvalid_o && rdata_o == $past(s_reg.ctrl);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read mismatch");

  property p_normal_read;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (rd_i && in_array && !margin_mode_o && !s_reg.pend) |=> rvalid_o &&
        rdata_o == $past(array_data_i);
  endproperty
  a_normal_read: assert property (p_normal_read) else $error("array read mismatch");

  property p_row_latch;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (wr_i && in_array && erase_mode_o && erase_size_o == faepc_pkg::SIZE_ROW &&
       s_reg.seq != faepc_pkg::SEQ_IDLE && !(s_reg.seq == faepc_pkg::SEQ_READY && overlap))
        |=> erase_addr_o == {1'b0, $past(addr_i[14:6]), 6'h00};
  endproperty
  a_row_latch: assert property (p_row_latch) else $error("row address not latched");

  property p_protect_drop;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (s_reg.seq == faepc_pkg::SEQ_READY && overlap) |=> !erase_mode_o && !program_mode_o;
  endproperty
  a_protect_drop: assert property (p_protect_drop) else $error("protected range kept");
endmodule : faepc_ctrl

// file: sim/test_flash_array_erase_program_control.sv
// self-checking bench for the flash array control block
`timescale 1ns/1ps
module test_flash_array_erase_program_control;
  logic        core_clk;
  logic        sys_rst;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  protect_data;
  logic [7:0]  array_data;
  logic [7:0]  rdata_o;
  logic        rvalid_o;
  logic        high_voltage_o;
  logic        pump_clk_en_o;
  logic        margin_mode_o;
  logic        erase_mode_o;
  logic        program_mode_o;
  logic [1:0]  erase_size_o;
  logic [15:0] erase_addr_o;
  logic        erase_go_o;
  logic        page_wr_o;
  logic [15:0] page_addr_o;
  logic [7:0]  page_data_o;
  int          fails;
  int          total_checks;
  int          pump_n;
  int          go_n;
  int          pw_n;
  logic [15:0] pw_addr;
  logic [7:0]  pw_data;
  logic [7:0]  rv;
  int          lat;
  logic [15:0] win_addr [8] = '{16'h0450, 16'h05ff, 16'h0e00, 16'h7fff,
                                16'h044f, 16'h0600, 16'h0dff, 16'h8000};

  faepc_ctrl uut (
    .core_clk_i     (core_clk),
    .sys_rst_i      (sys_rst),
    .addr_i         (addr),
    .wdata_i        (wdata),
    .wr_i           (wr),
    .rd_i           (rd),
    .protect_data_i (protect_data),
    .array_data_i   (array_data),
    .rdata_o        (rdata_o),
    .rvalid_o       (rvalid_o),
    .high_voltage_o (high_voltage_o),
    .pump_clk_en_o  (pump_clk_en_o),
    .margin_mode_o  (margin_mode_o),
    .erase_mode_o   (erase_mode_o),
    .program_mode_o (program_mode_o),
    .erase_size_o   (erase_size_o),
    .erase_addr_o   (erase_addr_o),
    .erase_go_o     (erase_go_o),
    .page_wr_o      (page_wr_o),
    .page_addr_o    (page_addr_o),
    .page_data_o    (page_data_o)
  );

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  // pulse monitors, sampled mid-cycle where the flops have settled
  always @(negedge core_clk) begin
    if (pump_clk_en_o === 1'b1) pump_n++;
    if (erase_go_o === 1'b1) go_n++;
    if (page_wr_o === 1'b1) begin
      pw_n++;
      pw_addr = page_addr_o;
      pw_data = page_data_o;
    end
  end

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check8

  task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check16

  task automatic check1(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : check1

  task automatic check_n(input string what, input int exp, input int got);
    total_checks++;
    if (got != exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check_n

  task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    #1;
  endtask : bus_write

  // returns data and the cycles from the taking edge to rvalid
  task automatic bus_read(input logic [15:0] a, output logic [7:0] d, output int n);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    n = 1;
    while (rvalid_o !== 1'b1 && n < 30) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    d = rdata_o;
  endtask : bus_read

  task automatic erase_seq(input logic [1:0] d, input logic [1:0] s,
                           input logic [15:0] target, input logic [7:0] prot);
    logic [7:0] tmp;
    int         t;
    bus_write(faepc_pkg::CTRL_ADDR, {d, s, 4'h2});
    protect_data <= prot;
    bus_read(faepc_pkg::PROTECT_ADDR, tmp, t);
    bus_read(faepc_pkg::CTRL_ADDR, tmp, t);
    bus_write(target, 8'h00);
    bus_write(faepc_pkg::CTRL_ADDR, {d, s, 4'ha});
  endtask : erase_seq

  function automatic logic [15:0] exp_base(input logic [1:0] s, input logic [15:0] a);
    case (s)
      2'h0:    return faepc_pkg::WIN0_LO;
      2'h1:    return a & 16'h4000;
      2'h2:    return a & 16'h7e00;
      default: return a & 16'h7fc0;
    endcase
  endfunction : exp_base

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  initial begin
    #200000;
    fails++;
    report_and_stop();
  end

  initial begin
    logic [1:0] d;
    fails = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    addr = 16'h0000;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    protect_data = 8'h00;
    array_data = 8'h00;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    bus_read(faepc_pkg::CTRL_ADDR, rv, lat);
    check8("ctrl after reset", faepc_pkg::CTRL_RESET, rv);
    check_n("plain read latency", 1, lat);
    // array windows answer, gaps read zero
    array_data <= 8'ha5;
    for (int k = 0; k < 8; k++) begin
      bus_read(win_addr[k], rv, lat);
      check8("window read", (k < 4) ? 8'ha5 : 8'h00, rv);
      check_n("window latency", 1, lat);
    end
    // interlocks
    bus_write(faepc_pkg::CTRL_ADDR, 8'h03);
    bus_read(faepc_pkg::CTRL_ADDR, rv, lat);
    check8("erase and program together", 8'h02, rv);
    check1("program dropped", 1'b0, program_mode_o);
    bus_write(faepc_pkg::CTRL_ADDR, 8'h0a);
    check1("hv without sequence", 1'b0, high_voltage_o);
    bus_write(faepc_pkg::CTRL_ADDR, 8'h00);
    // every divider and every erase size in turn
    for (int i = 0; i < 4; i++) begin
      d = 2'(i);
      erase_seq(d, d, 16'h5678, 8'h00);
      check16("erase base", exp_base(d, 16'h5678), erase_addr_o);
      check8("erase size", {6'h00, d}, {6'h00, erase_size_o});
      check1("hv on", 1'b1, high_voltage_o);
      // divider flop starts one cycle after hv rises
      @(posedge core_clk);
      #1;
      pump_n = 0;
      repeat (16) @(negedge core_clk);
      #1;
      check_n("pump pulses", (i == 0) ? 16 : (i == 3) ? 4 : 8, pump_n);
      bus_write(faepc_pkg::CTRL_ADDR, {d, d, 4'he});
      bus_read(faepc_pkg::CTRL_ADDR, rv, lat);
      check8("margin under hv", {d, d, 4'ha}, rv);
      go_n = 0;
      bus_write(faepc_pkg::CTRL_ADDR, {d, d, 4'h2});
      check1("hv off", 1'b0, high_voltage_o);
      // one last divider pulse may trail the hv edge
      @(posedge core_clk);
      #1;
      pump_n = 0;
      repeat (8) @(negedge core_clk);
      #1;
      check_n("pump idle", 0, pump_n);
      check_n("erase start pulse", 1, go_n);
      bus_write(faepc_pkg::CTRL_ADDR, 8'h00);
    end
    // protected target refuses, the same row below a higher protect bound is allowed
    bus_write(faepc_pkg::CTRL_ADDR, 8'h32);
    protect_data <= 8'h01;
    bus_read(faepc_pkg::PROTECT_ADDR, rv, lat);
    bus_write(16'h1000, 8'h00);
    // the refusal lands one cycle after the target write
    @(posedge core_clk);
    #1;
    check1("protected erase", 1'b0, erase_mode_o);
    bus_write(faepc_pkg::CTRL_ADDR, 8'h3a);
    check1("protected hv", 1'b0, high_voltage_o);
    erase_seq(2'h0, 2'h3, 16'h1000, 8'h08);
    check1("open row hv", 1'b1, high_voltage_o);
    bus_write(faepc_pkg::CTRL_ADDR, 8'h02);
    bus_write(faepc_pkg::CTRL_ADDR, 8'h00);
    // one page program then margin read
    bus_write(faepc_pkg::CTRL_ADDR, 8'h01);
    check1("program mode", 1'b1, program_mode_o);
    protect_data <= 8'h00;
    bus_read(faepc_pkg::PROTECT_ADDR, rv, lat);
    pw_n = 0;
    for (int k = 0; k < faepc_pkg::PAGE_BYTES; k++) begin
      bus_write(16'h0e08 + 16'(k), 8'h10 + 8'(k));
    end
    @(negedge core_clk);
    #1;
    check_n("page bytes", faepc_pkg::PAGE_BYTES, pw_n);
    check16("last page addr", 16'h0e0f, pw_addr);
    check8("last page data", 8'h17, pw_data);
    bus_write(faepc_pkg::CTRL_ADDR, 8'h09);
    check1("program hv", 1'b1, high_voltage_o);
    bus_write(faepc_pkg::CTRL_ADDR, 8'h01);
    bus_write(faepc_pkg::CTRL_ADDR, 8'h05);
    check1("margin allowed", 1'b1, margin_mode_o);
    array_data <= 8'h5a;
    bus_read(16'h0e08, rv, lat);
    check_n("margin latency", 2 + int'(faepc_pkg::MARGIN_STRETCH), lat);
    check8("margin data", 8'h5a, rv);
    // reset in mid operation
    erase_seq(2'h3, 2'h0, 16'h0500, 8'h00);
    check1("hv before reset", 1'b1, high_voltage_o);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    @(posedge core_clk);
    #1;
    check1("hv in reset", 1'b0, high_voltage_o);
    check1("erase in reset", 1'b0, erase_mode_o);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    bus_read(faepc_pkg::CTRL_ADDR, rv, lat);
    check8("ctrl after second reset", faepc_pkg::CTRL_RESET, rv);
    report_and_stop();
  end
endmodule : test_flash_array_erase_program_control
